// ### src/lcd_drive_consts.svh
// Offsets, field positions, reset values and timing counts of the LCD drive block
`ifndef LCD_DRIVE_CONSTS_SVH
`define LCD_DRIVE_CONSTS_SVH
`define ADDR_W            7
`define OFS_DISPLAY_CTRL  7'h13
`define OFS_DUTY_CLK      7'h14
`define OFS_RAM_FIRST     7'h50
`define OFS_RAM_LAST      7'h6f
`define CTRL_BLANK_BIT    0
`define CTRL_PWR_BIT      1
`define CTRL_LP_DISP_BIT  2
`define DUTY_LSB          0
`define CLKSEL_LSB        2
`define CTRL_RESET        3'h0
`define DUTY_CLK_RESET    4'h0
`define DIV_OSC_CL0       64
`define DIV_SYS_CL1       256
`define DIV_SYS_CL2       2048
`define DIV_SYS_CL3       4096
`define DIV_OSC_CL3       512
`endif

// ### src/lcd_drive_pkg.sv
// Types shared by the LCD drive block
package lcd_drive_pkg;
  typedef enum logic [1:0] {
    DUTY_QUARTER,
    DUTY_THIRD,
    DUTY_HALF,
    DUTY_STATIC
  } duty_t;
  typedef enum logic [1:0] {
    CLK_OSC_DIV64,
    CLK_SYS_DIV256,
    CLK_SYS_DIV2048,
    CLK_ALT
  } clk_sel_t;
  typedef struct packed {
    logic lp_display;
    logic power_switch;
    logic display_on;
  } display_control_t;
  typedef struct packed {
    clk_sel_t clk_sel;
    duty_t    duty;
  } duty_clock_t;
  typedef struct packed {
    logic [6:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;
endpackage : lcd_drive_pkg

// ### src/lcd_tick_div.sv
// Tick generator dividing a strobe by a selectable ratio
`timescale 1ns/1ns
`default_nettype none
module lcd_tick_div #(
  parameter int CNT_W = 13
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_step,
  input  wire logic [CNT_W-1:0] i_ratio,
  output logic                  o_tick
);
  logic [CNT_W-1:0] count_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      count_q <= '0;
    end else if (i_step) begin
      if (count_q >= i_ratio - CNT_W'(1)) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + CNT_W'(1);
      end
    end
  end

  assign o_tick = i_step && (count_q >= i_ratio - CNT_W'(1));
endmodule : lcd_tick_div
`default_nettype wire

// ### src/lcd_phase_gen.sv
// Common phase sequencer and frame alternation for the selected duty
`timescale 1ns/1ns
`default_nettype none
module lcd_phase_gen
  import lcd_drive_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire logic          i_tick,
  input  wire lcd_drive_pkg::duty_t i_duty,
  output logic [1:0]         o_phase,
  output logic               o_frame_odd
);
  import lcd_drive_pkg::*;

  logic [1:0] last_phase;

  always_comb begin
    case (i_duty)
      DUTY_QUARTER: last_phase = 2'h3;
      DUTY_THIRD:   last_phase = 2'h2;
      DUTY_HALF:    last_phase = 2'h1;
      default:      last_phase = 2'h0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_phase     <= 2'h0;
      o_frame_odd <= 1'b0;
    end else if (o_phase > last_phase) begin
      o_phase <= 2'h0;
    end else if (i_tick) begin
      if (o_phase >= last_phase) begin
        o_phase     <= 2'h0;
        o_frame_odd <= ~o_frame_odd;
      end else begin
        o_phase <= o_phase + 2'h1;
      end
    end
  end
endmodule : lcd_phase_gen
`default_nettype wire

// ### src/lcd_segment_drive_control.sv
// Segment LCD drive control: registers, display memory, clock choice, pin drive
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "lcd_drive_consts.svh"
module lcd_segment_drive_control
  import lcd_drive_pkg::*;
#(
  parameter int NUM_SEG = 32,
  parameter int NUM_COM = 4
) (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic [6:0]                i_addr,
  input  wire logic [31:0]               i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [31:0]               o_rdata,
  input  wire logic                      i_osc_tick,
  input  wire logic                      i_sys_tick,
  input  wire logic                      i_timer_a_clock_choice_bit,
  input  wire logic                      i_low_power_mode,
  output logic      [NUM_COM-1:0]        o_com,
  output logic      [NUM_COM-1:0]        o_com_select,
  output logic      [NUM_SEG-1:0]        o_segment_output,
  output logic                           o_power_switch,
  output logic                           o_lcd_clk_tick
);
  import lcd_drive_pkg::*;

  reg_req_t         req;
  display_control_t ctrl_q;
  duty_clock_t      duty_clk_q;
  logic [3:0]       mem_q [NUM_SEG];
  logic             ram_hit;
  logic [4:0]       ram_idx;
  logic             pins_grounded;
  logic             lp_show;
  logic             step;
  logic [12:0]      ratio;
  logic [1:0]       phase;
  logic             frame_odd;
  logic [NUM_SEG-1:0] seg_d;

  function automatic logic in_ram(input logic [6:0] a);
    return (a >= `OFS_RAM_FIRST) && (a <= `OFS_RAM_LAST);
  endfunction : in_ram

  assign req     = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
  assign ram_hit = in_ram(req.addr);
  assign ram_idx = 5'(req.addr - `OFS_RAM_FIRST);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (req.wr && req.addr == `OFS_DISPLAY_CTRL) begin
      ctrl_q <= req.wdata[2:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      duty_clk_q <= `DUTY_CLK_RESET;
    end else if (req.wr && req.addr == `OFS_DUTY_CLK) begin
      duty_clk_q <= req.wdata[3:0];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_SEG; i++) begin
        mem_q[i] <= 4'h0;
      end
    end else if (req.wr && ram_hit) begin
      mem_q[ram_idx] <= req.wdata[3:0];
    end
  end

  // Reads: memory readable, control registers write-only read zero
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0;
    end else if (req.rd && ram_hit) begin
      o_rdata <= {28'h0, mem_q[ram_idx]};
    end else begin
      o_rdata <= 32'h0;
    end
  end

  always_comb begin
    case (duty_clk_q.clk_sel)
      CLK_OSC_DIV64: begin
        step  = i_osc_tick;
        ratio = 13'(`DIV_OSC_CL0);
      end
      CLK_SYS_DIV256: begin
        step  = i_sys_tick;
        ratio = 13'(`DIV_SYS_CL1);
      end
      CLK_SYS_DIV2048: begin
        step  = i_sys_tick;
        ratio = 13'(`DIV_SYS_CL2);
      end
      default: begin
        if (i_timer_a_clock_choice_bit) begin
          step  = i_osc_tick;
          ratio = 13'(`DIV_OSC_CL3);
        end else begin
          step  = i_sys_tick;
          ratio = 13'(`DIV_SYS_CL3 - 1) + 13'h1;
        end
      end
    endcase
  end

  lcd_tick_div #(
    .CNT_W (13)
  ) u_div (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_step    (step),
    .i_ratio   (ratio),
    .o_tick    (o_lcd_clk_tick)
  );

  lcd_phase_gen u_phase (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_tick      (o_lcd_clk_tick),
    .i_duty      (duty_clk_q.duty),
    .o_phase     (phase),
    .o_frame_odd (frame_odd)
  );

  assign lp_show       = ctrl_q.lp_display;
  assign pins_grounded = i_low_power_mode && !lp_show;

  genvar g;
  generate
    for (g = 0; g < NUM_SEG; g++) begin : g_seg
      always_comb begin
        if (pins_grounded || !ctrl_q.display_on) begin
          seg_d[g] = 1'b0;
        end else if (duty_clk_q.duty == DUTY_STATIC) begin
          seg_d[g] = mem_q[g][0];
        end else begin
          seg_d[g] = mem_q[g][phase];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_segment_output <= '0;
    end else begin
      o_segment_output <= seg_d ^ {NUM_SEG{frame_odd && !pins_grounded && ctrl_q.display_on}};
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_com_select <= '0;
      o_com        <= '0;
    end else if (pins_grounded) begin
      o_com_select <= '0;
      o_com        <= '0;
    end else begin
      o_com_select <= NUM_COM'(1) << phase;
      o_com        <= frame_odd ? ~(NUM_COM'(1) << phase) : (NUM_COM'(1) << phase);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_power_switch <= 1'b0;
    end else begin
      o_power_switch <= ctrl_q.power_switch && !pins_grounded;
    end
  end
endmodule : lcd_segment_drive_control
`default_nettype wire

// ### verif/lcd_drive_props.sv
// Port checker for the LCD drive control block
`timescale 1ns/1ns
`default_nettype none
`include "lcd_drive_consts.svh"
module lcd_drive_props #(
  parameter int NUM_SEG = 32,
  parameter int NUM_COM = 4
) (
  input wire logic               i_clk,
  input wire logic               i_sys_rst,
  input wire logic [6:0]         i_addr,
  input wire logic [31:0]        i_wdata,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [31:0]        o_rdata,
  input wire logic               i_low_power_mode,
  input wire logic [NUM_COM-1:0] o_com,
  input wire logic [NUM_COM-1:0] o_com_select,
  input wire logic [NUM_SEG-1:0] o_segment_output,
  input wire logic               o_power_switch,
  input wire logic               o_lcd_clk_tick
);
  logic [2:0] ctl_q;
  logic       ram_a;
  assign ram_a = i_addr >= `OFS_RAM_FIRST && i_addr <= `OFS_RAM_LAST;
  // Mirror of the display control register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst)
      ctl_q <= 3'h0;
    else if (i_wr && i_addr == `OFS_DISPLAY_CTRL)
      ctl_q <= i_wdata[2:0];
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_blank; !$past(ctl_q[0]) |-> o_segment_output == '0; endproperty
  a_blank: assert property (p_blank) else $error("segments lit while blanked");
  property p_pwr;
    $stable(i_low_power_mode) |->
      o_power_switch == $past(ctl_q[1] && !(i_low_power_mode && !ctl_q[2]));
  endproperty
  a_pwr: assert property (p_pwr) else $error("power switch wrong");
  property p_gnd;
    $past(i_low_power_mode && !ctl_q[2]) && $stable(i_low_power_mode) |->
      o_com == '0 && o_com_select == '0 && o_segment_output == '0;
  endproperty
  a_gnd: assert property (p_gnd) else $error("pins not grounded");
  property p_wo;
    i_rd && (i_addr == `OFS_DISPLAY_CTRL || i_addr == `OFS_DUTY_CLK) |=> o_rdata == '0;
  endproperty
  a_wo: assert property (p_wo) else $error("control read not zero");
  property p_idle; !i_rd |=> o_rdata == '0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_unmap; i_rd && !ram_a |=> o_rdata == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_nib; i_rd && ram_a |=> o_rdata[31:4] == '0; endproperty
  a_nib: assert property (p_nib) else $error("memory read wider than nibble");
  property p_hot; $onehot0(o_com_select); endproperty
  a_hot: assert property (p_hot) else $error("several commons active");
  property p_tick; o_lcd_clk_tick |=> !o_lcd_clk_tick; endproperty
  a_tick: assert property (p_tick) else $error("clock tick too long");
endmodule : lcd_drive_props
bind lcd_segment_drive_control lcd_drive_props #(.NUM_SEG(NUM_SEG), .NUM_COM(NUM_COM)) u_props (
  .i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_low_power_mode,
  .o_com, .o_com_select, .o_segment_output, .o_power_switch, .o_lcd_clk_tick);
`default_nettype wire

// ### verif/lcd_glass_model.sv
// Segment glass seen from the drive pins
`timescale 1ns/1ns
`default_nettype none
module lcd_glass_model (
  input  wire logic        i_powered,
  input  wire logic [3:0]  i_com_select,
  input  wire logic [31:0] i_segment,
  output logic      [31:0] o_lit
);
  // Dark without bias supply or common
  assign o_lit = (i_powered && i_com_select != 4'h0) ? i_segment : 32'h0;
endmodule : lcd_glass_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the LCD drive control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [6:0]  i_addr = 7'h0;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_osc_tick = 1'b0;
  logic        i_sys_tick = 1'b0;
  logic        tmr = 1'b0;
  logic        i_low_power_mode = 1'b0;
  logic [31:0] o_rdata, o_segment_output, lit;
  logic [3:0]  o_com, o_com_select;
  logic        o_power_switch, o_lcd_clk_tick;
  int          errors = 0;
  int          num_checks = 0;
  localparam logic [31:0] PAT = 32'ha5c3_0f17;
  lcd_segment_drive_control dut (.i_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_osc_tick, .i_sys_tick, .i_timer_a_clock_choice_bit(tmr),
    .i_low_power_mode, .o_com, .o_com_select, .o_segment_output, .o_power_switch,
    .o_lcd_clk_tick);
  lcd_glass_model glass (.i_powered(o_power_switch), .i_com_select(o_com_select),
    .i_segment(o_segment_output), .o_lit(lit));
  initial forever #25 i_clk = ~i_clk;
  task automatic wrap_up;
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [31:0] e, input string n);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(n, e, o_rdata);
    @(posedge i_clk);
  endtask : rd
  task automatic gap(output int n);
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (o_lcd_clk_tick !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      errors++;
      wrap_up();
    end
  endtask : gap
  task automatic t_reset;
    chk("seg", 32'h0, o_segment_output);
    chk("pwr", 32'h0, o_power_switch);
    rd(7'h13, 32'h0, "ctrl rd");
    rd(7'h14, 32'h0, "duty rd");
    rd(7'h7f, 32'h0, "unmapped rd");
  endtask : t_reset
  task automatic t_ram;
    for (int i = 0; i < 32; i++) wr(7'h50 + 7'(i), {28'h0, 3'(i), PAT[i]});
    for (int i = 0; i < 32; i++) rd(7'h50 + 7'(i), {28'h0, 3'(i), PAT[i]}, "ram");
    wr(7'h13, 32'h0);
    chk("blank seg", 32'h0, o_segment_output);
    wr(7'h13, 32'h1);
    chk("shown seg", PAT, o_segment_output);
    wr(7'h50, 32'h0);
    chk("live seg", PAT ^ 32'h1, o_segment_output);
    wr(7'h50, {31'h0, PAT[0]});
  endtask : t_ram
  task automatic t_pwr;
    wr(7'h13, 32'h3);
    chk("pwr on", 32'h1, o_power_switch);
    chk("glass", PAT, lit);
    chk("com sel", 32'h1, o_com_select);
    chk("com lvl", 32'h1, o_com);
    wr(7'h13, 32'h1);
    chk("pwr off", 32'h0, o_power_switch);
  endtask : t_pwr
  task automatic t_lp;
    wr(7'h14, 32'h0);
    wr(7'h13, 32'h3);
    i_low_power_mode <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk("lp seg", 32'h0, o_segment_output);
    chk("lp com", 32'h0, {o_com, o_com_select});
    chk("lp pwr", 32'h0, o_power_switch);
    wr(7'h13, 32'h7);
    chk("lp show", PAT, o_segment_output);
    chk("lp pwr on", 32'h1, o_power_switch);
    i_low_power_mode <= 1'b0;
    wr(7'h13, 32'h1);
  endtask : t_lp
  task automatic t_duty;
    logic [3:0] acc;
    i_osc_tick <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      wr(7'h14, 32'(d));
      acc = 4'h0;
      repeat (600) begin
        @(posedge i_clk);
        #1 acc |= o_com_select;
      end
      chk("commons used", 32'(4'hf >> d), 32'(acc));
    end
  endtask : t_duty
  task automatic t_clk;
    int r[5] = '{64, 256, 2048, 4096, 512};
    int n;
    i_sys_tick <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      tmr <= (k == 4);
      wr(7'h14, 32'(((k > 3 ? 3 : k) << 2) | 3));
      gap(n);
      gap(n);
      chk("clk period", 32'(r[k]), 32'(n));
    end
  endtask : t_clk
  initial begin
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1 t_reset();
    t_ram();
    t_pwr();
    t_lp();
    t_duty();
    t_clk();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
